// ===== dpw_pkg.sv
`default_nettype none
package dpw_pkg;

    // Array and register geometry
    localparam int DATA_W = 10;
    localparam int NUM_STORE = 4;
    localparam int SEL_W = 2;
    localparam int ADDR_W = 2;
    localparam int TAP_COUNT = 1024;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;

    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int NV_WRITE_TIME_MS = 10;
    // Longest time, so round down
    localparam int NV_WRITE_CYCLES = (CLK_HZ / 1000) * NV_WRITE_TIME_MS;

    // Bit counter limits
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_BYTE_LAST = 4'h7;
    localparam logic [3:0] CNT_WORD_LAST = 4'hf;

    // Identification byte fields
    localparam int ID_ADDR_HI = 2;
    localparam int ID_ADDR_LO = 1;
    localparam int ID_RW_BIT = 0;

    // Instruction byte fields
    localparam int INS_OP_HI = 7;
    localparam int INS_OP_LO = 5;
    localparam int INS_SEL_HI = 3;
    localparam int INS_SEL_LO = 2;

    // Commands as {read_not_write, opcode}
    localparam logic [3:0] OP_READ_WIPER = 4'hc;
    localparam logic [3:0] OP_WRITE_WIPER = 4'h5;
    localparam logic [3:0] OP_READ_STORE = 4'hd;
    localparam logic [3:0] OP_WRITE_STORE = 4'h6;
    localparam logic [3:0] OP_XFER_TO_WIPER = 4'he;
    localparam logic [3:0] OP_XFER_TO_STORE = 4'h7;
    localparam logic [3:0] OP_READ_STATUS = 4'ha;

    // Reset values
    localparam logic [DATA_W-1:0] WIPER_RESET = 10'h000;
    localparam logic [DATA_W-1:0] STORE_RESET_VALUE = 10'h000;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_ID     = 7'h02,
        ST_INSTR  = 7'h04,
        ST_WDATA  = 7'h08,
        ST_RDATA  = 7'h10,
        ST_DONE   = 7'h20,
        ST_IGNORE = 7'h40
    } dpw_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
        logic [ADDR_W-1:0] strap;
    } dpw_pins_t;

    localparam dpw_pins_t PINS_RESET = '0;

    typedef struct packed {
        logic valid;
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] data;
    } dpw_nv_req_t;

    // Low byte first, then the two top bits in the low end of the second byte
    function automatic logic [WORD_W-1:0] dpw_pack_word(input logic [DATA_W-1:0] value);
        dpw_pack_word = {value[7:0], 6'h00, value[9:8]};
    endfunction : dpw_pack_word

    function automatic logic [DATA_W-1:0] dpw_unpack_word(input logic [WORD_W-1:0] word);
        dpw_unpack_word = {word[1:0], word[15:8]};
    endfunction : dpw_unpack_word

    function automatic logic [WORD_W-1:0] dpw_pack_status(input logic busy);
        dpw_pack_status = {7'h00, busy, 8'h00};
    endfunction : dpw_pack_status

endpackage : dpw_pkg
`default_nettype wire

// ===== dpw_nv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_nv_timer
    import dpw_pkg::*;
#(
    parameter int CYCLES = NV_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control
    input wire logic start,
    output logic busy
);

    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    if (CYCLES < 2) begin : g_bad_cycles
        $error("dpw_nv_timer needs at least two cycles");
    end

    logic [CNT_W-1:0] remain;
    logic [CNT_W-1:0] run_len;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            remain <= '0;
            busy <= 1'b0;
        end else if (start) begin
            remain <= LOAD;
            busy <= 1'b1;
        end else if (remain > ONE) begin
            remain <= remain - ONE;
        end else begin
            remain <= '0;
            busy <= 1'b0;
        end
    end

    // Helper for the length check only
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !busy) begin
            run_len <= '0;
        end else begin
            run_len <= run_len + ONE;
        end
    end

    chk_busy_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
        start |=> busy ##1 busy)
        else $error("busy flag did not follow write start");

    chk_busy_length: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(busy) |-> ($past(run_len) == LOAD - ONE))
        else $error("write cycle length wrong");

endmodule : dpw_nv_timer
`default_nettype wire

// ===== dpw_tap_decode.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_tap_decode
    import dpw_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Wiper in, switch enables out
    input wire logic [DATA_W-1:0] wiper,
    output logic [TAP_COUNT-1:0] tap_select
);

    if (TAP_COUNT != (1 << DATA_W)) begin : g_bad_taps
        $error("tap count must match wiper width");
    end

    // Reset keeps tap zero on so the one-hot property holds throughout
    for (genvar i = 0; i < TAP_COUNT; i++) begin : g_tap
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                tap_select[i] <= (i == 0);
            end else begin
                tap_select[i] <= (wiper == DATA_W'(i));
            end
        end
    end

    chk_tap_onehot: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $onehot(tap_select))
        else $error("more or fewer than one tap switch on");

    chk_tap_value: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $stable(wiper) |=> tap_select[$past(wiper)])
        else $error("tap switch does not match wiper");

endmodule : dpw_tap_decode
`default_nettype wire

// ===== dpw_wiper_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_wiper_ctrl
    import dpw_pkg::*;
#(
    parameter int NV_CYCLES = NV_WRITE_CYCLES,
    parameter logic [DATA_W-1:0] STORE_RESET = STORE_RESET_VALUE
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Serial bus pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si_in,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic [ADDR_W-1:0] strap_address,
    output logic so_out,
    output logic so_oe,
    // Potentiometer and power state
    output logic [TAP_COUNT-1:0] tap_select,
    output logic [DATA_W-1:0] wiper_position,
    output logic write_busy_flag,
    output logic standby
);

    if (NV_CYCLES < 2) begin : g_bad_cycles
        $error("write cycle count too small");
    end

    dpw_pins_t pins_raw;
    dpw_pins_t pins_meta;
    dpw_pins_t pins_sync;
    dpw_pins_t pins_prev;
    logic sck_rise;
    logic sck_fall;
    logic cs_active;
    logic cs_fall;
    logic cs_rise;
    logic step;
    logic armed;
    dpw_state_t state;
    logic [3:0] bit_cnt;
    logic [WORD_W-1:0] rx_shift;
    logic [WORD_W-1:0] tx_shift;
    logic [BYTE_W-1:0] next_byte;
    logic [WORD_W-1:0] next_word;
    logic rw_bit;
    logic [3:0] op_code;
    logic [3:0] op_now;
    logic [SEL_W-1:0] sel;
    logic [SEL_W-1:0] sel_now;
    logic [DATA_W-1:0] sel_data;
    logic ev_id_done;
    logic ev_instr_done;
    logic ev_word_done;
    logic addr_match;
    logic op_is_read;
    logic recall_pending;
    logic [DATA_W-1:0] store [NUM_STORE];
    dpw_nv_req_t pend;
    logic wp_low_seen;
    logic nv_start;
    logic out_started;

    // Every pin is asynchronous to ref_clk; the serial clock must be slow
    // enough that each level lasts several ref_clk periods.
    assign pins_raw = {cs_n, sck, si_in, hold_n, wp_n, strap_address};

    // Sync reset to zero so a select held low through reset is not taken
    // as a falling edge.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pins_meta <= PINS_RESET;
            pins_sync <= PINS_RESET;
            pins_prev <= PINS_RESET;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
            pins_prev <= pins_sync;
        end
    end

    assign sck_rise = pins_sync.sck && !pins_prev.sck;
    assign sck_fall = !pins_sync.sck && pins_prev.sck;
    assign cs_active = !pins_sync.cs_n;
    assign cs_fall = !pins_sync.cs_n && pins_prev.cs_n;
    assign cs_rise = pins_sync.cs_n && !pins_prev.cs_n;
    assign step = cs_active && pins_sync.hold_n && sck_rise;

    assign next_byte = {rx_shift[BYTE_W-2:0], pins_sync.si};
    assign next_word = {rx_shift[WORD_W-2:0], pins_sync.si};
    assign op_now = {rw_bit, next_byte[INS_OP_HI:INS_OP_LO]};
    assign sel_now = next_byte[INS_SEL_HI:INS_SEL_LO];
    assign sel_data = store[sel_now];
    assign addr_match = (next_byte[ID_ADDR_HI:ID_ADDR_LO] == pins_sync.strap);
    assign ev_id_done = step && (state == ST_ID) && (bit_cnt == CNT_BYTE_LAST);
    assign ev_instr_done = step && (state == ST_INSTR) && (bit_cnt == CNT_BYTE_LAST);
    assign ev_word_done = step && (state == ST_WDATA) && (bit_cnt == CNT_WORD_LAST);
    assign op_is_read = (op_now == OP_READ_WIPER) || (op_now == OP_READ_STORE) || (op_now == OP_READ_STATUS);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            armed <= 1'b0;
        end else if (cs_fall) begin
            armed <= 1'b1;
        end
    end

    // Sequence state
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            bit_cnt <= CNT_ZERO;
            rx_shift <= '0;
            rw_bit <= 1'b0;
            op_code <= '0;
            sel <= '0;
        end else if (!cs_active) begin
            state <= ST_IDLE;
            bit_cnt <= CNT_ZERO;
        end else if (state == ST_IDLE) begin
            if (armed || cs_fall) begin
                state <= ST_ID;
            end
        end else if (step) begin
            rx_shift <= next_word;
            bit_cnt <= bit_cnt + 4'h1;
            case (state)
                ST_ID: begin
                    if (bit_cnt == CNT_BYTE_LAST) begin
                        bit_cnt <= CNT_ZERO;
                        rw_bit <= next_byte[ID_RW_BIT];
                        state <= addr_match ? ST_INSTR : ST_IGNORE;
                    end
                end
                ST_INSTR: begin
                    if (bit_cnt == CNT_BYTE_LAST) begin
                        bit_cnt <= CNT_ZERO;
                        op_code <= op_now;
                        sel <= sel_now;
                        case (op_now)
                            OP_READ_WIPER, OP_READ_STORE, OP_READ_STATUS: state <= ST_RDATA;
                            OP_WRITE_WIPER, OP_WRITE_STORE: state <= ST_WDATA;
                            OP_XFER_TO_WIPER, OP_XFER_TO_STORE: state <= ST_DONE;
                            default: state <= ST_IGNORE;
                        endcase
                    end
                end
                ST_WDATA, ST_RDATA: begin
                    if (bit_cnt == CNT_WORD_LAST) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE, ST_IGNORE: begin
                    bit_cnt <= bit_cnt;
                end
                default: state <= ST_IGNORE;
            endcase
        end
    end

    // Wiper register; volatile, so reset stands in for power-up
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wiper_position <= WIPER_RESET;
            recall_pending <= 1'b1;
        end else if (recall_pending) begin
            wiper_position <= store[0];
            recall_pending <= 1'b0;
        end else if (ev_instr_done && (op_now == OP_XFER_TO_WIPER)) begin
            wiper_position <= sel_data;
        end else if (ev_word_done && (op_code == OP_WRITE_WIPER)) begin
            wiper_position <= dpw_unpack_word(next_word);
        end
    end

    // Pending stored-setting write, held until the select rises
    always_ff @(posedge ref_clk) begin
        if (!reset_n || cs_rise) begin
            pend <= '0;
        end else if (ev_instr_done && (op_now == OP_XFER_TO_STORE)) begin
            pend <= '{valid: 1'b1, sel: sel_now, data: wiper_position};
        end else if (ev_word_done && (op_code == OP_WRITE_STORE)) begin
            pend <= '{valid: 1'b1, sel: sel, data: dpw_unpack_word(next_word)};
        end
    end

    // Protect low at any point of the frame spoils its write
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wp_low_seen <= 1'b0;
        end else if (cs_fall) begin
            wp_low_seen <= !pins_sync.wp_n;
        end else if (cs_active && !pins_sync.wp_n) begin
            wp_low_seen <= 1'b1;
        end
    end

    // A write that arrives while a cycle runs is dropped
    assign nv_start = cs_rise && pend.valid && pins_sync.wp_n && !wp_low_seen && !write_busy_flag;

    // Stored settings; reset loads a fixed image in place of retained contents
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_STORE; i++) begin
                store[i] <= STORE_RESET;
            end
        end else if (nv_start) begin
            store[pend.sel] <= pend.data;
        end
    end

    dpw_nv_timer #(
        .CYCLES(NV_CYCLES)
    ) u_nv_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(nv_start),
        .busy(write_busy_flag)
    );

    dpw_tap_decode u_tap_decode (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .wiper(wiper_position),
        .tap_select(tap_select)
    );

    // Read data path
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tx_shift <= '0;
            so_out <= 1'b0;
            out_started <= 1'b0;
        end else if (ev_instr_done && op_is_read) begin
            out_started <= 1'b0;
            case (op_now)
                OP_READ_WIPER: tx_shift <= dpw_pack_word(wiper_position);
                OP_READ_STORE: tx_shift <= dpw_pack_word(sel_data);
                OP_READ_STATUS: tx_shift <= dpw_pack_status(write_busy_flag);
                default: tx_shift <= '0;
            endcase
        end else if (state != ST_RDATA) begin
            out_started <= 1'b0;
        end else if (sck_fall && cs_active && pins_sync.hold_n) begin
            so_out <= tx_shift[WORD_W-1];
            tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
            out_started <= 1'b1;
        end
    end

    // Output tri-stated on hold as well, so a shared wire is free while paused
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= cs_active && pins_sync.hold_n && (state == ST_RDATA) && (out_started || sck_fall);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            standby <= 1'b0;
        end else begin
            standby <= pins_sync.cs_n && !write_busy_flag;
        end
    end

    chk_so_falling: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !sck_fall |=> $stable(so_out))
        else $error("serial output moved off a falling edge");

    chk_sample_rising: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!sck_rise && cs_active && state != ST_IDLE) |=> $stable(bit_cnt) && $stable(rx_shift))
        else $error("input shifted without a rising edge");

    chk_hold_freeze: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!pins_sync.hold_n && cs_active && state != ST_IDLE) |=> $stable(state) && $stable(bit_cnt))
        else $error("sequence moved while paused");

    chk_addr_mismatch: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ev_id_done && !addr_match) |=> (state == ST_IGNORE) [*2])
        else $error("mismatched address not ignored");

    chk_ignore_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state == ST_IGNORE) |=> !so_oe && $stable(wiper_position))
        else $error("ignored frame drove output or wiper");

    chk_deselect_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pins_sync.cs_n |=> !so_oe && (state == ST_IDLE))
        else $error("deselected device still active");

    chk_select_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cs_fall |=> (state == ST_ID) || pins_sync.cs_n)
        else $error("select did not start a sequence");

    chk_unarmed_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!armed && !cs_fall) |=> (state == ST_IDLE))
        else $error("traffic accepted before first select edge");

    chk_protect_block: assert property (@(posedge ref_clk) disable iff (!reset_n)
        nv_start |-> $past(pins_sync.wp_n) && pins_sync.wp_n)
        else $error("write started while protected");

    chk_output_read_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
        so_oe |-> $past(state == ST_RDATA))
        else $error("output driven outside read data");

    chk_xfer_wiper: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ev_instr_done && op_now == OP_XFER_TO_WIPER && !recall_pending) |=> wiper_position == $past(sel_data))
        else $error("transfer to wiper lost");

    chk_power_recall: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(reset_n) |=> (wiper_position == $past(store[0])))
        else $error("power-up recall missing");

    chk_save_on_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
        nv_start |-> cs_rise ##1 write_busy_flag)
        else $error("save started off the select rise");

endmodule : dpw_wiper_ctrl
`default_nettype wire

// ===== dpw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_host_model
    import dpw_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Serial bus
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so_out,
    input wire logic so_oe
);
    // Six cycles per phase covers the pin synchronisers
    localparam int HALF = 6;
    initial begin
        cs_n = 1'b0;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // One whole frame; pause_at below zero means no pause
    task automatic frame(input logic [31:0] bits, input int pause_at, output logic [15:0] rd, output int oe_n);
        oe_n = 0;
        rd = 16'h0000;
        cs_n <= 1'b0;
        tick(HALF);
        for (int i = 31; i >= 0; i--) begin
            sck <= 1'b0;
            si <= bits[i];
            tick(HALF);
            if (i == pause_at) begin
                hold_n <= 1'b0;
                // Clocks while paused must be ignored
                repeat (2) begin
                    tick(HALF);
                    sck <= 1'b1;
                    tick(HALF);
                    sck <= 1'b0;
                end
                tick(HALF);
                hold_n <= 1'b1;
                tick(HALF);
            end
            // Released wire reads as the opposite of the last driven level
            if (i < 16) begin
                rd[i] = so_oe ? so_out : ~so_out;
            end
            oe_n += int'(so_oe);
            sck <= 1'b1;
            tick(HALF);
        end
        sck <= 1'b0;
        tick(HALF);
        cs_n <= 1'b1;
        si <= ~si;
        tick(3 * HALF);
    endtask : frame
endmodule : dpw_host_model
`default_nettype wire

// ===== dpw_wiper_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_wiper_ctrl_tb_top
    import dpw_pkg::*;
;
    localparam logic [DATA_W-1:0] INIT = 10'h2a5;
    localparam int NV = 2000;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n = 1'b1;
    logic [ADDR_W-1:0] strap = 2'h0;
    logic cs_n, sck, si, hold_n, so_out, so_oe, busy, standby;
    logic [TAP_COUNT-1:0] taps;
    logic [DATA_W-1:0] wiper, v;
    logic [DATA_W-1:0] exp_s [NUM_STORE];
    logic [15:0] rd;
    int fails = 0;
    int total_checks = 0;
    int oe_n;
    always #50 ref_clk = ~ref_clk;
    dpw_wiper_ctrl #(.NV_CYCLES(NV), .STORE_RESET(INIT)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .cs_n(cs_n), .sck(sck), .si_in(si), .hold_n(hold_n), .wp_n(wp_n), .strap_address(strap),
        .so_out(so_out), .so_oe(so_oe), .tap_select(taps), .wiper_position(wiper),
        .write_busy_flag(busy), .standby(standby));
    dpw_host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .so_out(so_out), .so_oe(so_oe));
    task automatic end_sim();
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            $display("MISMATCH at %0t: %s", $time, m);
            fails++;
        end
    endtask : chk
    function automatic logic [DATA_W-1:0] unword(input logic [15:0] w);
        return {w[1:0], w[15:8]};
    endfunction : unword
    // Frame: id byte, instruction byte, value low byte then top bits
    task automatic run(input logic [3:0] c, input logic [1:0] s, input logic [1:0] a,
                       input logic [DATA_W-1:0] x, input int pause_at);
        host.frame({4'h5, 1'b0, a, c, 1'b0, s, 2'h0, x[7:0], 6'h00, x[9:8]}, pause_at, rd, oe_n);
    endtask : run
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy === 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n <= NV, "save too long");
        if (n == 3000) end_sim();
    endtask : wait_idle
    initial begin
        void'($urandom(32'h82954321));
        strap <= 2'($urandom);
        for (int i = 0; i < NUM_STORE; i++) exp_s[i] = INIT;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(wiper === INIT && taps === TAP_COUNT'(1'b1) << INIT, "recall");
        // Select held low through reset gives no falling edge
        run(OP_WRITE_WIPER, 2'h0, strap, 10'h155, -1);
        chk(wiper === INIT, "accepted before arming");
        chk(standby === 1'b1 && so_oe === 1'b0, "standby");
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : DATA_W'($urandom);
            run(OP_WRITE_WIPER, 2'h0, strap, v, (i == 2) ? 5 : -1);
            chk(wiper === v, "wiper write");
            chk(taps === TAP_COUNT'(1'b1) << v, "tap select");
            run(OP_READ_WIPER, 2'h0, strap, ~v, (i == 3) ? 9 : -1);
            chk(unword(rd) === v && oe_n == 16, "wiper read");
        end
        run(OP_WRITE_WIPER, 2'h0, ~strap, 10'h0aa, -1);
        chk(wiper === v, "foreign write");
        run(4'h4, 2'h0, strap, 10'h0aa, -1);
        chk(wiper === v && oe_n == 0, "unknown command");
        fork
            run(OP_READ_WIPER, 2'h0, strap ^ 2'h1, 10'h000, -1);
            begin
                repeat (60) @(posedge ref_clk);
                chk(standby === 1'b0, "not active");
            end
        join
        chk(oe_n == 0, "foreign read drove output");
        for (int s = 0; s < NUM_STORE; s++) begin
            exp_s[s] = DATA_W'($urandom);
            run(OP_WRITE_STORE, 2'(s), strap, exp_s[s], -1);
            chk(busy === 1'b1 && standby === 1'b0, "save start");
            run(OP_READ_STATUS, 2'h0, strap, 10'h000, -1);
            chk(rd[8] === 1'b1, "status busy");
            wait_idle();
            run(OP_READ_STATUS, 2'h0, strap, 10'h000, -1);
            chk(rd === 16'h0000, "status idle");
        end
        for (int s = 0; s < NUM_STORE; s++) begin
            run(OP_READ_STORE, 2'(s), strap, 10'h000, -1);
            chk(unword(rd) === exp_s[s], "setting read");
            run(OP_XFER_TO_WIPER, 2'(s), strap, 10'h000, -1);
            chk(wiper === exp_s[s], "copy to wiper");
        end
        wp_n <= 1'b0;
        run(OP_WRITE_STORE, 2'h1, strap, ~exp_s[1], -1);
        run(OP_XFER_TO_STORE, 2'h2, strap, 10'h000, -1);
        chk(busy === 1'b0, "protected save");
        wp_n <= 1'b1;
        run(OP_XFER_TO_STORE, 2'h2, strap, 10'h000, -1);
        exp_s[2] = exp_s[3];
        wait_idle();
        for (int s = 1; s < 3; s++) begin
            run(OP_READ_STORE, 2'(s), strap, 10'h000, -1);
            chk(unword(rd) === exp_s[s], "copy to setting");
        end
        reset_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(wiper === INIT, "second recall");
        end_sim();
    end
endmodule : dpw_wiper_ctrl_tb_top
`default_nettype wire
